// ==== dcpm_cfg.v ====
// clock, power-down and modulation configuration of a two-channel synthesizer
// assumes a single-cycle register port master and asynchronous pin inputs
//
// Contract
// - multiplier field bits 22:18; values 4..20 enable it, sysclk = ref times value
// - field below 4 or above 20 bypasses multiplier, factor one
// - one vco gain bit selects low or high range, resets low
// - charge pump setting resets to the 75 microampere code
// - clock mode pin high enables crystal oscillator, low selects input buffer
// - oscillator with multiplier bypassed gives sysclk equal to oscillator
// - bypassed multiplier shuts the pll down
// - dac scale bits 9:8: 11 full, 01 half, 10 quarter, 00 eighth
// - channel bits 7:6 power down dac and digital; further bit clock input
// - power-down pin high makes software power-down bits don't care
// - pin high, bit 6 clear: digital and dac digital down only
// - pin high, bit 6 set: everything down including dacs and pll
// - pin low: software power-down bits govern
// - logic one requests low power on every power-down control
// - fifteen profile words per channel at 0x0a..0x18, pins select one
// - 0x04..0x06 hold base frequency, phase, amplitude as first entry
// - frequency 32 bits, phase 14, amplitude 10, msb aligned in profiles
// - modulation type bits 23:22: off, amplitude, frequency, phase
// - sixteen-level modulation on one channel uses all four profile pins
// - amplitude ramp acts through the 10-bit scaler from spare pins
// - level bits 9:8 select two, four, eight or sixteen levels
// - profile pin assignment bits 14:12 give pins to a channel
// - ramp pin low requests ramp up, high ramp down
//
// Local design decision: the strobed register port.
`include "dcpm_regs.vh"
module dcpm_cfg (
  input wire mclk_i,
  input wire arst_n_i,
  input wire [4:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [3:0] profile_i,
  input wire [3:0] sdio_i,
  input wire external_powerdown_pin_i,
  input wire clk_mode_sel_i,
  output reg pll_enable_o,
  output reg [4:0] pll_mult_o,
  output reg vco_high_o,
  output reg [1:0] charge_pump_o,
  output reg osc_enable_o,
  output reg clkin_pd_o,
  output reg [1:0] dac_pd_o,
  output reg [1:0] dig_pd_o,
  output reg [1:0] dac_bias_pd_o,
  output reg [3:0] dac_scale_o,
  output reg [63:0] freq_o,
  output reg [27:0] phase_o,
  output reg [19:0] ampl_o,
  output reg [1:0] ramp_down_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [31:0] func_one_reg;
  reg [7:0] chan_sel_reg;
  reg [31:0] chan_func_reg [0:1];
  reg [31:0] base_freq_reg [0:1];
  reg [13:0] base_phase_reg [0:1];
  reg [9:0] base_ampl_reg [0:1];
  reg [31:0] prof_reg [0:29];
  reg [3:0] prof_meta_reg;
  reg [3:0] prof_sync_reg;
  reg [3:0] sdio_meta_reg;
  reg [3:0] sdio_sync_reg;
  reg pdn_meta_reg;
  reg pdn_sync_reg;
  reg cms_meta_reg;
  reg cms_sync_reg;
  reg [3:0] sel_reg [0:1];
  reg [1:0] ramp_reg;
  reg [3:0] sel_next [0:1];
  reg [1:0] ramp_next;
  reg [31:0] rdata_next;
  reg [4:0] pidx;

  wire [4:0] mult = func_one_reg[`DCPM_F1_MULT_HI:`DCPM_F1_MULT_LO];
  wire [2:0] profile_pin_assignment_field = func_one_reg[`DCPM_F1_PPC_HI:`DCPM_F1_PPC_LO];
  wire [1:0] lvl = func_one_reg[`DCPM_F1_LVL_HI:`DCPM_F1_LVL_LO];
  wire [1:0] rmode = func_one_reg[`DCPM_F1_RAMP_HI:`DCPM_F1_RAMP_LO];
  wire ext_pd = pdn_sync_reg;
  // pin high with bit 6 set
  wire full_pd = ext_pd && func_one_reg[`DCPM_F1_FULL_PD];
  wire mult_on = (mult >= `DCPM_MULT_MIN) && (mult <= `DCPM_MULT_MAX);
  wire [4:0] prof_off = addr_i - `DCPM_IDX_PROF_FIRST;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two-stage profile and sdio pin sync
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prof_meta_reg <= 4'h0;
      prof_sync_reg <= 4'h0;
      sdio_meta_reg <= 4'h0;
      sdio_sync_reg <= 4'h0;
    end else begin
      prof_meta_reg <= profile_i;
      prof_sync_reg <= prof_meta_reg;
      sdio_meta_reg <= sdio_i;
      sdio_sync_reg <= sdio_meta_reg;
    end
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pdn_meta_reg <= 1'b0;
      pdn_sync_reg <= 1'b0;
      cms_meta_reg <= 1'b0;
      cms_sync_reg <= 1'b0;
    end else begin
      pdn_meta_reg <= external_powerdown_pin_i;
      pdn_sync_reg <= pdn_meta_reg;
      cms_meta_reg <= clk_mode_sel_i;
      cms_sync_reg <= cms_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  integer i;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      func_one_reg <= `DCPM_F1_RESET;
      chan_sel_reg <= `DCPM_CS_RESET;
      for (i = 0; i < 2; i = i + 1) begin
        chan_func_reg[i] <= `DCPM_CF_RESET;
        base_freq_reg[i] <= 32'h0000_0000;
        base_phase_reg[i] <= 14'h0000;
        base_ampl_reg[i] <= 10'h000;
      end
      for (i = 0; i < 30; i = i + 1) begin
        prof_reg[i] <= 32'h0000_0000;
      end
    end else if (wr_i) begin
      if (addr_i == `DCPM_IDX_FUNC_ONE) begin
        func_one_reg <= wdata_i;
      end
      if (addr_i == `DCPM_IDX_CHAN_SEL) begin
        chan_sel_reg <= wdata_i[7:0];
      end
      // channel-addressed words go to every enabled channel
      for (i = 0; i < 2; i = i + 1) begin
        if (chan_sel_reg[`DCPM_CS_CH0 + i]) begin
          if (addr_i == `DCPM_IDX_CHAN_FUNC) begin
            chan_func_reg[i] <= wdata_i;
          end
          if (addr_i == `DCPM_IDX_BASE_FREQ) begin
            base_freq_reg[i] <= wdata_i;
          end
          if (addr_i == `DCPM_IDX_BASE_PHASE) begin
            base_phase_reg[i] <= wdata_i[13:0];
          end
          if (addr_i == `DCPM_IDX_BASE_AMPL) begin
            base_ampl_reg[i] <= wdata_i[9:0];
          end
          if (addr_i >= `DCPM_IDX_PROF_FIRST && addr_i <= `DCPM_IDX_PROF_LAST) begin
            prof_reg[i * 15 + prof_off] <= wdata_i;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    pidx = chan_sel_reg[`DCPM_CS_CH0] ? 5'h00 : 5'h0f;
    if (rd_i) begin
      case (addr_i)
        `DCPM_IDX_FUNC_ONE: rdata_next = func_one_reg;
        `DCPM_IDX_CHAN_SEL: rdata_next = {24'h000000, chan_sel_reg};
        `DCPM_IDX_CHAN_FUNC: rdata_next = chan_func_reg[pidx[0] ? 1 : 0];
        `DCPM_IDX_BASE_FREQ: rdata_next = base_freq_reg[pidx[0] ? 1 : 0];
        `DCPM_IDX_BASE_PHASE: rdata_next = {18'h00000, base_phase_reg[pidx[0] ? 1 : 0]};
        `DCPM_IDX_BASE_AMPL: rdata_next = {22'h000000, base_ampl_reg[pidx[0] ? 1 : 0]};
        `DCPM_IDX_STATUS: rdata_next = {20'h00000, sel_reg[1], sel_reg[0], ramp_reg,
                                        ext_pd, pll_enable_o};
        default: begin
          if (addr_i >= `DCPM_IDX_PROF_FIRST && addr_i <= `DCPM_IDX_PROF_LAST) begin
            rdata_next = prof_reg[pidx + prof_off];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // profile selection
  // ----------------------------------------------------------------
  // level, pin assignment, ramp pins
  always @* begin
    sel_next[0] = 4'h0;
    sel_next[1] = 4'h0;
    ramp_next = 2'h0;
    case (lvl)
      `DCPM_LVL_2: begin
        if (rmode == `DCPM_RAMP_P23) begin
          sel_next[0] = {3'h0, prof_sync_reg[0]};
          sel_next[1] = {3'h0, prof_sync_reg[1]};
          ramp_next = prof_sync_reg[3:2];
        end else begin
          sel_next[0] = {3'h0, prof_sync_reg[2]};
          sel_next[1] = {3'h0, prof_sync_reg[3]};
        end
      end
      `DCPM_LVL_4: begin
        sel_next[0] = {2'h0, prof_sync_reg[0], prof_sync_reg[1]};
        sel_next[1] = {2'h0, prof_sync_reg[2], prof_sync_reg[3]};
      end
      `DCPM_LVL_8: begin
        sel_next[profile_pin_assignment_field[0]] = {1'h0, prof_sync_reg[0], prof_sync_reg[1], prof_sync_reg[2]};
        if (rmode == `DCPM_RAMP_P3) begin
          ramp_next[profile_pin_assignment_field[0]] = prof_sync_reg[3];
        end
      end
      // all four pins to one channel
      `DCPM_LVL_16: begin
        sel_next[profile_pin_assignment_field[0]] = {prof_sync_reg[0], prof_sync_reg[1], prof_sync_reg[2],
                            prof_sync_reg[3]};
      end
      default: begin
        sel_next[0] = 4'h0;
      end
    endcase
    if (rmode == `DCPM_RAMP_SDIO) begin
      ramp_next = sdio_sync_reg[2:1];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      wire [31:0] cf = chan_func_reg[c];
      wire [1:0] mtype = cf[`DCPM_CF_MOD_HI:`DCPM_CF_MOD_LO];
      wire use_prof = (sel_reg[c] != 4'h0);
      wire [4:0] sel_ofs = {1'b0, sel_reg[c]} - 5'h01;
      wire [4:0] prof_base = (c == 0) ? 5'h00 : 5'h0f;
      // index n picks profile word n
      wire [4:0] pw_idx = use_prof ? prof_base + sel_ofs : 5'h00;
      wire [31:0] pw = prof_reg[pw_idx];
      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sel_reg[c] <= 4'h0;
          dac_scale_o[2 * c +: 2] <= 2'h3;
          dac_pd_o[c] <= 1'b0;
          dig_pd_o[c] <= 1'b0;
          dac_bias_pd_o[c] <= 1'b0;
          freq_o[32 * c +: 32] <= 32'h0000_0000;
          phase_o[14 * c +: 14] <= 14'h0000;
          ampl_o[10 * c +: 10] <= 10'h000;
        end else begin
          sel_reg[c] <= sel_next[c];
          dac_scale_o[2 * c +: 2] <= cf[`DCPM_CF_SCALE_HI:`DCPM_CF_SCALE_LO];
          if (ext_pd) begin
            dig_pd_o[c] <= 1'b1;
            dac_pd_o[c] <= 1'b1;
            dac_bias_pd_o[c] <= func_one_reg[`DCPM_F1_FULL_PD];
          end else begin
            dac_pd_o[c] <= cf[`DCPM_CF_DAC_PD];
            dac_bias_pd_o[c] <= cf[`DCPM_CF_DAC_PD];
            dig_pd_o[c] <= cf[`DCPM_CF_DIG_PD];
          end
          freq_o[32 * c +: 32] <= base_freq_reg[c];
          phase_o[14 * c +: 14] <= base_phase_reg[c];
          ampl_o[10 * c +: 10] <= base_ampl_reg[c];
          if (use_prof) begin
            case (mtype)
              `DCPM_MOD_AMPL: ampl_o[10 * c +: 10] <= pw[31:22];
              `DCPM_MOD_FREQ: freq_o[32 * c +: 32] <= pw;
              `DCPM_MOD_PHASE: phase_o[14 * c +: 14] <= pw[31:18];
              default: ampl_o[10 * c +: 10] <= base_ampl_reg[c];
            endcase
          end
        end
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0000_0000;
      ramp_reg <= 2'h0;
      ramp_down_o <= 2'h0;
    end else begin
      rdata_o <= rdata_next;
      ramp_reg <= ramp_next;
      ramp_down_o <= ramp_reg;
    end
  end

  // ----------------------------------------------------------------
  // pll control
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_enable_o <= 1'b0;
      pll_mult_o <= 5'h01;
      vco_high_o <= 1'b0;
      charge_pump_o <= `DCPM_CP_75UA;
    end else begin
      pll_enable_o <= mult_on && !full_pd;
      pll_mult_o <= mult_on ? mult : 5'h01;
      vco_high_o <= func_one_reg[`DCPM_F1_VCO_GAIN];
      charge_pump_o <= func_one_reg[`DCPM_F1_CP_HI:`DCPM_F1_CP_LO];
    end
  end

  // ----------------------------------------------------------------
  // reference clock input
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_enable_o <= 1'b0;
      clkin_pd_o <= 1'b0;
    end else begin
      osc_enable_o <= cms_sync_reg && !full_pd;
      clkin_pd_o <= ext_pd ? func_one_reg[`DCPM_F1_FULL_PD] :
                    func_one_reg[`DCPM_F1_CLKIN_PD];
    end
  end

endmodule

// ==== dcpm_cfg_checker.sv ====
// checker bound to the configuration block ports
// assumes pins stay steady for several cycles between changes
// ----------------------------------------
// clock and power relations
// ----------------------------------------
module dcpm_cfg_chk (
  input wire mclk_i,
  input wire arst_n_i,
  input wire external_powerdown_pin_i,
  input wire clk_mode_sel_i,
  input wire pll_enable_o,
  input wire [4:0] pll_mult_o,
  input wire vco_high_o,
  input wire [1:0] charge_pump_o,
  input wire osc_enable_o,
  input wire clkin_pd_o,
  input wire [1:0] dig_pd_o,
  input wire [1:0] dac_pd_o,
  input wire [1:0] dac_bias_pd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_pd_hi;
    external_powerdown_pin_i [*5];
  endsequence
  sequence s_pd_lo;
    !external_powerdown_pin_i [*5];
  endsequence
  property p_mult;
    pll_enable_o |-> pll_mult_o >= 5'h04 && pll_mult_o <= 5'h14;
  endproperty
  a_mult: assert property (p_mult) else $error("pll on out of range");
  property p_bypass;
    pll_mult_o == 5'h01 || (pll_mult_o >= 5'h04 && pll_mult_o <= 5'h14);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bad factor");
  property p_pll_off;
    pll_mult_o == 5'h01 |-> !pll_enable_o;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll on in bypass");
  property p_rst;
    $rose(arst_n_i) |-> !vco_high_o && charge_pump_o == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pll reset state");
  property p_full;
    s_pd_hi ##0 (dac_bias_pd_o == 2'h3) |-> (!pll_enable_o && !osc_enable_o && clkin_pd_o);
  endproperty
  a_full: assert property (p_full) else $error("full power-down");
  property p_fast_clk;
    s_pd_hi ##0 (dac_bias_pd_o == 2'h0) |-> !clkin_pd_o;
  endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("clock input down, fast mode");
  property p_fast;
    s_pd_hi |-> dig_pd_o == 2'h3;
  endproperty
  a_fast: assert property (p_fast) else $error("pin power-down");
  property p_pin_lo;
    s_pd_lo |-> dac_bias_pd_o == dac_pd_o;
  endproperty
  a_pin_lo: assert property (p_pin_lo) else $error("bias down, pin low");
  property p_osc_on;
    (clk_mode_sel_i && !external_powerdown_pin_i) [*5] |-> osc_enable_o;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("osc off");
  property p_osc_off;
    (!clk_mode_sel_i) [*5] |-> !osc_enable_o;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc on");
endmodule
bind dcpm_cfg dcpm_cfg_chk dcpm_cfg_chk_inst (.mclk_i, .arst_n_i, .external_powerdown_pin_i,
  .clk_mode_sel_i, .pll_enable_o, .pll_mult_o, .vco_high_o, .charge_pump_o, .osc_enable_o,
  .clkin_pd_o, .dig_pd_o, .dac_pd_o, .dac_bias_pd_o);

// ==== dcpm_cfg_tb.sv ====
// self-checking bench with a reference model of registers and selection
// assumes the host model drives the register port, the bench the pins
module dcpm_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] profile_i = 4'h0, sdio = 4'h0;
  logic pwr_pin = 1'b0, clk_sel = 1'b0, wr, rd, pll_en, vco, osc, clkin_pd, inr;
  logic [4:0] addr, mult, m;
  logic [31:0] wdata, rdata, q, e0, e1, seed = 32'h8679e917, fr1 = 32'h0, cs = 32'hf0;
  logic [1:0] cp, dac_pd, dig_pd, bias_pd, ramp;
  logic [3:0] scale;
  logic [63:0] freq;
  logic [27:0] phase;
  logic [19:0] ampl;
  logic [31:0] mr [2][32];
  logic [4:0] mv [6] = '{5'h00, 5'h03, 5'h04, 5'h14, 5'h15, 5'h1f};
  logic [31:0] cfg_f1 [10] = '{32'h5100, 32'h5100, 32'h5100, 32'h5100, 32'h1300, 32'h0200,
    32'h0400, 32'h0000, 32'h1a00, 32'h0f00};
  logic [1:0] cfg_mt [10] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3};
  int err_count = 0, checks = 0, cyc = 0;
  dcpm_host dcpm_host_inst (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  dcpm_cfg dcpm_cfg_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .profile_i(profile_i),
    .sdio_i(sdio), .external_powerdown_pin_i(pwr_pin), .clk_mode_sel_i(clk_sel),
    .pll_enable_o(pll_en), .pll_mult_o(mult), .vco_high_o(vco), .charge_pump_o(cp),
    .osc_enable_o(osc), .clkin_pd_o(clkin_pd), .dac_pd_o(dac_pd), .dig_pd_o(dig_pd),
    .dac_bias_pd_o(bias_pd), .dac_scale_o(scale), .freq_o(freq), .phase_o(phase),
    .ampl_o(ampl), .ramp_down_o(ramp));
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int idx(int c, logic [3:0] p);
    case (fr1[9:8])
      2'h0: return (fr1[11:10] == 2'h1) ? p[c] : p[2 + c];
      2'h1: return c ? {p[2], p[3]} : {p[0], p[1]};
      2'h2: return (fr1[12] == c) ? {p[0], p[1], p[2]} : 0;
      default: return (fr1[12] == c) ? {p[0], p[1], p[2], p[3]} : 0;
    endcase
  endfunction
  function automatic logic [31:0] ex(int c, logic [3:0] p, int k);
    int i;
    logic [31:0] b, w;
    logic [1:0] t;
    i = idx(c, p);
    b = mr[c][4 + k];
    w = mr[c][9 + i];
    t = (k == 0) ? 2'h2 : ((k == 1) ? 2'h3 : 2'h1);
    if (i == 0 || mr[c][3][23:22] != t)
      return (k == 0) ? b : ((k == 1) ? b[13:0] : b[9:0]);
    return (k == 0) ? w : ((k == 1) ? w[31:18] : w[31:22]);
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic w(input logic [4:0] a, input logic [31:0] d);
    dcpm_host_inst.wr(a, d);
    if (a == 5'h01) fr1 = d;
    if (a == 5'h00) cs = d;
    for (int c = 0; c < 2; c++)
      if (cs[6 + c] && a inside {[5'h03:5'h06], [5'h0a:5'h18]})
        mr[c][a] = (a == 5'h03) ? d & 32'hffff_bfff : d;
  endtask
  task automatic rdr(input logic [4:0] a);
    logic [31:0] x;
    x = 32'h0;
    if (a == 5'h01) x = fr1;
    if (a == 5'h00) x = cs;
    if (a inside {5'h03, 5'h04, [5'h0a:5'h18]}) x = mr[cs[6] ? 0 : 1][a];
    dcpm_host_inst.rd(a, q);
    chk(q, x);
  endtask
  task automatic stop_test();
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 32; a++)
        mr[c][a] = (a == 3) ? 32'h302 : 32'h0;
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    tick(1);
    chk({mult, scale, vco, cp}, {5'h01, 4'hf, 3'h0});
    rdr(5'h03);
    rdr(5'h00);
    w(5'h1e, seed);
    rdr(5'h1e);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      m = (i < 6) ? mv[i] : seed[4:0];
      inr = m >= 5'h04 && m <= 5'h14;
      w(5'h01, (seed & 32'h0083_0080) | {9'h0, m, 18'h0});
      if (inr)
        dcpm_host_inst.lock_wait();
      else
        tick(3);
      chk({pll_en, mult}, {inr, inr ? m : 5'h01});
      chk({vco, cp, clkin_pd}, {fr1[23], fr1[17:16], fr1[7]});
    end
    for (int s = 0; s < 4; s++) begin
      clk_sel <= s[0];
      w(5'h00, 32'h40);
      w(5'h03, 32'h4000 | (s << 8) | (s << 6));
      w(5'h00, 32'h80);
      w(5'h03, ((3 - s) << 8) | ((3 - s) << 6));
      rdr(5'h03);
      tick(6);
      chk(scale[3:0], {mr[1][3][9:8], mr[0][3][9:8]});
      chk({dac_pd, dig_pd}, {mr[1][3][7], mr[0][3][7], mr[1][3][6], mr[0][3][6]});
      chk(osc, s[0]);
    end
    pwr_pin <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      w(5'h01, 32'h0028_0080 | (b << 6));
      tick(6);
      chk(dig_pd, 2'h3);
      chk({bias_pd, clkin_pd, pll_en, osc}, {b[0], b[0], b[0], !b[0], !b[0]});
      if (b)
        chk(dac_pd, 2'h3);
    end
    pwr_pin <= 1'b0;
    tick(6);
    chk({dac_pd, clkin_pd}, {mr[1][3][7], mr[0][3][7], 1'b1});
    for (int c = 0; c < 2; c++) begin
      w(5'h00, c ? 32'h80 : 32'h40);
      for (int a = 4; a < 25; a++) begin
        seed = lfsr(seed);
        if (a < 7 || a > 9)
          w(a[4:0], seed);
      end
    end
    w(5'h00, 32'hc0);
    for (int k = 0; k < 10; k++) begin
      w(5'h03, {8'h0, cfg_mt[k], 22'h300});
      w(5'h01, cfg_f1[k]);
      for (int p = 0; p < 16; p++) begin
        profile_i <= p[3:0];
        seed = lfsr(seed);
        sdio <= seed[3:0];
        tick(6);
        e0 = ex(0, p[3:0], 0);
        e1 = ex(1, p[3:0], 0);
        chk(freq, {e1, e0});
        e0 = ex(0, p[3:0], 1);
        e1 = ex(1, p[3:0], 1);
        chk(phase, {e1[13:0], e0[13:0]});
        e0 = ex(0, p[3:0], 2);
        e1 = ex(1, p[3:0], 2);
        chk(ampl, {e1[9:0], e0[9:0]});
        e0 = 32'h0;
        if (fr1[11:8] == 4'h4)
          e0[1:0] = p[3:2];
        if (fr1[11:8] == 4'ha)
          e0[fr1[12]] = p[3];
        if (fr1[11:10] == 2'h3)
          e0[1:0] = sdio[2:1];
        chk(ramp, e0[1:0]);
      end
    end
    dcpm_host_inst.rd(5'h1f, q);
    chk(q, {20'h0, 4'(idx(1, 4'hf)), 4'(idx(0, 4'hf)), e0[1:0], pwr_pin, 1'b0});
    stop_test();
  end
endmodule

// ==== dcpm_host.sv ====
// host model: register port master
// assumes the clock of the block; one request at a time
// ----------------------------------------
// bus tasks
// ----------------------------------------
module dcpm_host #(parameter int LOCK_CYC = 40) (
  input wire mclk_i,
  input wire [31:0] rdata_i,
  output logic [4:0] addr_o = 5'h00,
  output logic [31:0] wdata_o = 32'h0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= (a == 5'h03) ? d & 32'hffff_bfff : d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    d = rdata_i;
  endtask
  task automatic lock_wait();
    repeat (LOCK_CYC) @(posedge mclk_i);
  endtask
endmodule

// ==== dcpm_regs.vh ====
// register map, field positions, reset values and timing counts of the clock,
// power and modulation configuration block
// assumes a 20 mhz control clock and 32-bit register words indexed by address
`ifndef DCPM_REGS_VH
`define DCPM_REGS_VH
// register indexes; byte address is four times the index
`define DCPM_IDX_FUNC_ONE 5'h01
`define DCPM_IDX_CHAN_SEL 5'h00
`define DCPM_IDX_CHAN_FUNC 5'h03
`define DCPM_IDX_BASE_FREQ 5'h04
`define DCPM_IDX_BASE_PHASE 5'h05
`define DCPM_IDX_BASE_AMPL 5'h06
`define DCPM_IDX_PROF_FIRST 5'h0a
`define DCPM_IDX_PROF_LAST 5'h18
`define DCPM_IDX_STATUS 5'h1f
// function word one fields
`define DCPM_F1_VCO_GAIN 23
`define DCPM_F1_MULT_HI 22
`define DCPM_F1_MULT_LO 18
`define DCPM_F1_CP_HI 17
`define DCPM_F1_CP_LO 16
`define DCPM_F1_PPC_HI 14
`define DCPM_F1_PPC_LO 12
`define DCPM_F1_RAMP_HI 11
`define DCPM_F1_RAMP_LO 10
`define DCPM_F1_LVL_HI 9
`define DCPM_F1_LVL_LO 8
`define DCPM_F1_CLKIN_PD 7
`define DCPM_F1_FULL_PD 6
// channel function word fields
`define DCPM_CF_MOD_HI 23
`define DCPM_CF_MOD_LO 22
`define DCPM_CF_SWEEP 14
`define DCPM_CF_SCALE_HI 9
`define DCPM_CF_SCALE_LO 8
`define DCPM_CF_DAC_PD 7
`define DCPM_CF_DIG_PD 6
// channel select bits
`define DCPM_CS_CH0 6
`define DCPM_CS_CH1 7
// values
`define DCPM_MULT_MIN 5'h04
`define DCPM_MULT_MAX 5'h14
`define DCPM_CP_75UA 2'h0
`define DCPM_F1_RESET 32'h0000_0000
`define DCPM_CF_RESET 32'h0000_0302
`define DCPM_CS_RESET 8'hf0
`define DCPM_MOD_OFF 2'h0
`define DCPM_MOD_AMPL 2'h1
`define DCPM_MOD_FREQ 2'h2
`define DCPM_MOD_PHASE 2'h3
`define DCPM_LVL_2 2'h0
`define DCPM_LVL_4 2'h1
`define DCPM_LVL_8 2'h2
`define DCPM_LVL_16 2'h3
`define DCPM_RAMP_OFF 2'h0
`define DCPM_RAMP_P23 2'h1
`define DCPM_RAMP_P3 2'h2
`define DCPM_RAMP_SDIO 2'h3
// pll lock wait, informational for the host
`define DCPM_LOCK_TIME_US 1000
`define DCPM_CLK_MHZ 20
`define DCPM_LOCK_CYCLES (`DCPM_LOCK_TIME_US * `DCPM_CLK_MHZ)
`endif
